/* File: hdl/bank_router_defines.vh */
`ifndef BANK_ROUTER_DEFINES_VH
`define BANK_ROUTER_DEFINES_VH
// bank count and the fixed bank map
`define BANKS 12
`define SYS_BANKS 8
`define BANK_RSV_LO 8
`define BANK_RSV_HI 9
`define BANK_RAM 10
`define BANK_PERIPH 11
// address compare geometry
`define ADDR_W 32
`define CMP_W 17
`define CMP_TOP 31
`define CMP_BOT 15
`define DRAM_HI_W 12
`define DRAM_LO_W 5
// machine choice field encodings
`define MACHINE_CHOICE_FIELD_W 3
`define MACHINE_CHOICE_FIELD_CS 3'h0
`define MACHINE_CHOICE_FIELD_DRAM 3'h1
`define MACHINE_CHOICE_FIELD_UPMA 3'h4
`define MACHINE_CHOICE_FIELD_UPMB 3'h5
`define MACHINE_CHOICE_FIELD_THIRD_PATTERN_MACHINE 3'h6
`define UPM_COUNT 3
`define UPM_A 0
`define UPM_B 1
`define UPM_C 2
`define BUS_LOCAL 1'b1
// port sizes
`define PSZ_W 2
`define PSZ_64 2'h0
`define PSZ_32 2'h1
`define PSZ_16 2'h2
`define PSZ_8 2'h3
// bursts, bridge timing, masters, parity
`define BURST_BEATS 3'h4
`define BRIDGE_CLKS 3'h5
`define BRIDGE_LAST 3'h4
`define CNT_W 3
`define MASTERS 4
`define DATA_W 64
`define DPAR_W 8
`define APAR_W 4
`endif

/* File: hdl/bank_compare.v */
`timescale 1ns/10ps
`include "bank_router_defines.vh"

module bank_compare (
  input wire [`CMP_W-1:0] addrHi,            // upper address lines
  input wire [`CMP_W-1:0] baseAddr,          // bank base address field
  input wire [`CMP_W-1:0] compareMask,       // compare mask field
  input wire [`DRAM_HI_W-1:0] dramMask,      // dram compare mask
  input wire [`DRAM_LO_W-1:0] lowerDramMask, // lower dram compare mask
  input wire isDram,                         // bank runs on the dram machine
  input wire bankOn,                         // bank valid and not reserved
  output wire hit                            // address falls in this bank
);
  wire [`CMP_W-1:0] useMask;
  wire [`CMP_W-1:0] diff;

  // dram banks swap in their own split mask [R3]
  assign useMask = isDram ? {dramMask, lowerDramMask} : compareMask; // [R2]
  // set mask bits take part in the compare, cleared bits drop out
  assign diff = (addrHi ^ baseAddr) & useMask; // [R1]
  assign hit = bankOn & ~(|diff);
endmodule // bank_compare

/* File: hdl/memory_bank_decode_router.v */
// Summary of operation
// R1: match upper 17 address bits against bank base
// R2: chip-select and pattern banks use compare mask
// R3: dram banks use dram and lower masks
// R4: several hits: lowest bank number wins
// R5: system access to local bank crosses over
// R6: local access to system bank is ignored
// R7: banks zero to seven sit on system bus
// R8: bank ten: local, third pattern machine, RAM
// R9: bank eleven: local, chip-select machine, peripherals
// R10: banks eight and nine reserved, never match
// R11: each bank picks exactly one machine
// R12: pattern machine bus bit picks bank bus
// R13: bridge only carries system to local
// R14: bridge transfer completes in five bus clocks
// R15: local bus runs on the system clock
// R16: router moves control only, no bus data
// R17: system width 64 or 32, local 64
// R18: port sizes 64, 32, 16 and 8
// R19: both buses carry four-beat bursts
// R20: address and data parity on both buses
// R21: arbitrate system masters, local has no external
// R22: falling edge read latch when both bits set
// R23: unmatched address selects nothing, starts nothing
`timescale 1ns/10ps
`include "bank_router_defines.vh"

module memory_bank_decode_router (
  input wire clk_sys,                                  // bus clock
  input wire rstn,                                     // async reset, low
  input wire [`BANKS*`CMP_W-1:0] bankBase,             // base per bank
  input wire [`BANKS*`CMP_W-1:0] compareMask,          // mask per bank
  input wire [`BANKS*`DRAM_HI_W-1:0] dramCompareMask,  // dram mask
  input wire [`BANKS*`DRAM_LO_W-1:0] lowerDramMask,    // lower dram mask
  input wire [`BANKS*`MACHINE_CHOICE_FIELD_W-1:0] machineChoice,       // machine per bank
  input wire [`BANKS*`PSZ_W-1:0] bankPortSize,         // port per bank
  input wire [`BANKS-1:0] bankValid,                   // bank enabled
  input wire [`UPM_COUNT-1:0] busChoiceBit,            // 1 = local bus
  input wire [`UPM_COUNT-1:0] lineFourDisable,         // per pattern mach.
  input wire fallingEdgeLatch,                         // pattern word bit
  input wire sysWide,                                  // 1 = 64-bit bus
  input wire [`MASTERS-1:0] sysBusReq,                 // master requests
  input wire sysReq,                                   // system access
  input wire [`ADDR_W-1:0] sysAddr,                    // system address
  input wire [`APAR_W-1:0] sysAddrPar,                 // odd byte parity
  input wire sysBurst,                                 // four-beat burst
  input wire locReq,                                   // local access
  input wire [`ADDR_W-1:0] locAddr,                    // local address
  input wire [`APAR_W-1:0] locAddrPar,                 // odd byte parity
  input wire locBurst,                                 // four-beat burst
  input wire rdValid,                                  // read beat valid
  input wire [`DATA_W-1:0] rdData,                     // read data pins
  input wire [`DPAR_W-1:0] rdDataPar,                  // odd byte parity
  output reg [`MASTERS-1:0] sysBusGrant_reg,           // one-hot grant
  output reg [`BANKS-1:0] sysBankSel_reg,              // system bank pulse
  output reg [`BANKS-1:0] locBankSel_reg,              // local bank pulse
  output reg dramStart_reg,                            // dram machine go
  output reg csStart_reg,                              // chip-select go
  output reg [`UPM_COUNT-1:0] upmStart_reg,            // pattern mach. go
  output reg [`PSZ_W-1:0] portSize_reg,                // effective port
  output reg [`CNT_W-1:0] burstBeats_reg,              // beats of access
  output reg noMatch_reg,                              // nothing selected
  output reg addrParErr_reg,                           // address parity
  output reg locIgnored_reg,                           // dropped local acc.
  output reg locAccepted_reg,                          // local acc. taken
  output reg bridgeActive_reg,                         // crossing in flight
  output reg bridgeDone_reg,                           // crossing complete
  output reg [`DATA_W-1:0] readData_reg,               // latched read data
  output reg readValid_reg,                            // read data valid
  output reg readParErr_reg                            // data parity error
);
  reg rstSync1_reg;
  reg rstSync2_reg;
  wire rstnInt;
  reg [`CNT_W-1:0] bridgeCnt_reg;
  reg [`UPM_COUNT-1:0] curUpm_reg;
  reg [`DATA_W-1:0] fallData_reg;
  reg [`DPAR_W-1:0] fallPar_reg;
  reg [`BANKS-1:0] bankOn;
  reg [`BANKS-1:0] bankLocal;
  reg [`BANKS-1:0] bankDram;
  reg [`MACHINE_CHOICE_FIELD_W-1:0] bankMach [0:`BANKS-1];
  wire [`BANKS-1:0] sysHitRaw;
  wire [`BANKS-1:0] locHitRaw;
  reg [`BANKS-1:0] sysPick;
  reg [`BANKS-1:0] locPick;
  reg [`MACHINE_CHOICE_FIELD_W-1:0] sysMach;
  reg [`MACHINE_CHOICE_FIELD_W-1:0] locMach;
  reg [`PSZ_W-1:0] sysPsz;
  reg [`PSZ_W-1:0] locPsz;
  reg sysFound;
  reg locFound;
  wire sysParOk;
  wire locParOk;
  wire sysTake;
  wire locTake;
  wire sysToLocal;
  wire sysToSys;
  reg [`MACHINE_CHOICE_FIELD_W-1:0] goMach;
  reg [`PSZ_W-1:0] goPsz;
  reg goBurst;
  reg goValid;
  reg [`MASTERS-1:0] grantNext;
  reg fallSel;
  reg [`DATA_W-1:0] capData;
  reg [`DPAR_W-1:0] capPar;
  reg parBad;
  integer i;
  integer k;
  integer j;
  integer m;

  // reset leaves through two flops so release is clean on this clock
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end
    else
    begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstnInt = rstSync2_reg;

  // fixed bank map; the local bus shares clk_sys, no crossing [R15]
  always @*
  begin
    for (i = 0; i < `BANKS; i = i + 1)
    begin
      bankMach[i] = machineChoice[i*`MACHINE_CHOICE_FIELD_W +: `MACHINE_CHOICE_FIELD_W]; // [R11]
      bankOn[i] = bankValid[i];
      bankLocal[i] = 1'b0;
      if (i == `BANK_RSV_LO || i == `BANK_RSV_HI)
        bankOn[i] = 1'b0; // [R10]
      else if (i == `BANK_RAM)
      begin
        bankMach[i] = `MACHINE_CHOICE_FIELD_THIRD_PATTERN_MACHINE; // [R8]
        bankLocal[i] = 1'b1;
      end
      else if (i == `BANK_PERIPH)
      begin
        bankMach[i] = `MACHINE_CHOICE_FIELD_CS; // [R9]
        bankLocal[i] = 1'b1;
      end
      else if (i < `SYS_BANKS)
      begin
        // system banks unless their pattern machine is moved [R7]
        case (bankMach[i])
          `MACHINE_CHOICE_FIELD_UPMA: bankLocal[i] = busChoiceBit[`UPM_A] == `BUS_LOCAL;
          `MACHINE_CHOICE_FIELD_UPMB: bankLocal[i] = busChoiceBit[`UPM_B] == `BUS_LOCAL;
          `MACHINE_CHOICE_FIELD_THIRD_PATTERN_MACHINE: bankLocal[i] = busChoiceBit[`UPM_C] == `BUS_LOCAL;
          default: bankLocal[i] = 1'b0; // [R12]
        endcase
      end
      bankDram[i] = bankMach[i] == `MACHINE_CHOICE_FIELD_DRAM;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `BANKS; g = g + 1)
    begin : cmp
      bank_compare sysCmp (
        .addrHi(sysAddr[`CMP_TOP:`CMP_BOT]),
        .baseAddr(bankBase[g*`CMP_W +: `CMP_W]),
        .compareMask(compareMask[g*`CMP_W +: `CMP_W]),
        .dramMask(dramCompareMask[g*`DRAM_HI_W +: `DRAM_HI_W]),
        .lowerDramMask(lowerDramMask[g*`DRAM_LO_W +: `DRAM_LO_W]),
        .isDram(bankDram[g]),
        .bankOn(bankOn[g]),
        .hit(sysHitRaw[g])
      );
      bank_compare locCmp (
        .addrHi(locAddr[`CMP_TOP:`CMP_BOT]),
        .baseAddr(bankBase[g*`CMP_W +: `CMP_W]),
        .compareMask(compareMask[g*`CMP_W +: `CMP_W]),
        .dramMask(dramCompareMask[g*`DRAM_HI_W +: `DRAM_HI_W]),
        .lowerDramMask(lowerDramMask[g*`DRAM_LO_W +: `DRAM_LO_W]),
        .isDram(bankDram[g]),
        .bankOn(bankOn[g]),
        .hit(locHitRaw[g])
      );
    end
  endgenerate

  // scan from the top down so the lowest hit is the one that sticks
  always @*
  begin
    sysPick = {`BANKS{1'b0}};
    locPick = {`BANKS{1'b0}};
    sysMach = `MACHINE_CHOICE_FIELD_CS;
    locMach = `MACHINE_CHOICE_FIELD_CS;
    sysPsz = `PSZ_64;
    locPsz = `PSZ_64;
    sysFound = 1'b0;
    locFound = 1'b0;
    for (k = `BANKS - 1; k >= 0; k = k - 1)
    begin
      if (sysHitRaw[k])
      begin
        sysPick = {`BANKS{1'b0}};
        sysPick[k] = 1'b1; // [R4]
        sysMach = bankMach[k];
        sysPsz = bankPortSize[k*`PSZ_W +: `PSZ_W];
        sysFound = 1'b1;
      end
      if (locHitRaw[k])
      begin
        locPick = {`BANKS{1'b0}};
        locPick[k] = 1'b1; // [R4]
        locMach = bankMach[k];
        locPsz = bankPortSize[k*`PSZ_W +: `PSZ_W];
        locFound = 1'b1;
      end
    end
  end

  // odd parity per address byte [R20]
  // a good byte and its parity bit differ in their xor
  assign sysParOk = &(sysAddrPar ^ {^sysAddr[31:24], ^sysAddr[23:16],
                                    ^sysAddr[15:8], ^sysAddr[7:0]});
  assign locParOk = &(locAddrPar ^ {^locAddr[31:24], ^locAddr[23:16],
                                    ^locAddr[15:8], ^locAddr[7:0]});

  // system side waits while the bridge holds the local bus
  assign sysTake = sysReq & ~bridgeActive_reg;
  assign sysToLocal = sysTake & sysParOk & sysFound & |(sysPick & bankLocal);
  assign sysToSys = sysTake & sysParOk & sysFound & |(sysPick & ~bankLocal);
  // local side has no path outward and loses to any system access [R21]
  assign locTake = locReq & ~bridgeActive_reg & ~sysTake;

  // one machine launch per cycle; system access has precedence
  always @*
  begin
    goValid = 1'b0;
    goMach = `MACHINE_CHOICE_FIELD_CS;
    goPsz = `PSZ_64;
    goBurst = 1'b0;
    if (sysToSys | sysToLocal)
    begin
      goValid = 1'b1;
      goMach = sysMach;
      goPsz = sysPsz;
      goBurst = sysBurst;
      // a 32-bit system bus caps wide system-bank ports at 32; crossings to local banks keep 64 [R17]
      if (!sysWide && !sysToLocal && sysPsz == `PSZ_64)
        goPsz = `PSZ_32;
    end
    else if (locTake & locParOk & locFound & |(locPick & bankLocal))
    begin
      goValid = 1'b1;
      goMach = locMach;
      goPsz = locPsz;
      goBurst = locBurst;
    end
  end

  always @(posedge clk_sys or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      sysBankSel_reg <= {`BANKS{1'b0}};
      locBankSel_reg <= {`BANKS{1'b0}};
      dramStart_reg <= 1'b0;
      csStart_reg <= 1'b0;
      upmStart_reg <= {`UPM_COUNT{1'b0}};
      portSize_reg <= `PSZ_64;
      burstBeats_reg <= {`CNT_W{1'b0}};
      noMatch_reg <= 1'b0;
      addrParErr_reg <= 1'b0;
      locIgnored_reg <= 1'b0;
      locAccepted_reg <= 1'b0;
      curUpm_reg <= {`UPM_COUNT{1'b0}};
    end
    else
    begin
      sysBankSel_reg <= (sysToSys | sysToLocal) ? sysPick : {`BANKS{1'b0}};
      locBankSel_reg <= (locTake & locParOk & ~(sysToSys | sysToLocal))
                        ? (locPick & bankLocal) : {`BANKS{1'b0}};
      // at most one machine kicked per accepted access; a choice code outside the five encodings kicks none [R11]
      dramStart_reg <= goValid & (goMach == `MACHINE_CHOICE_FIELD_DRAM);
      csStart_reg <= goValid & (goMach == `MACHINE_CHOICE_FIELD_CS);
      upmStart_reg <= {goValid & (goMach == `MACHINE_CHOICE_FIELD_THIRD_PATTERN_MACHINE),
                       goValid & (goMach == `MACHINE_CHOICE_FIELD_UPMB),
                       goValid & (goMach == `MACHINE_CHOICE_FIELD_UPMA)};
      if (goValid)
      begin
        portSize_reg <= goPsz; // [R18]
        burstBeats_reg <= goBurst ? `BURST_BEATS : 3'h1; // [R19]
        curUpm_reg <= {goMach == `MACHINE_CHOICE_FIELD_THIRD_PATTERN_MACHINE, goMach == `MACHINE_CHOICE_FIELD_UPMB,
                       goMach == `MACHINE_CHOICE_FIELD_UPMA};
      end
      // no bank hit means no select and no machine [R23]
      noMatch_reg <= (sysTake & sysParOk & ~sysFound) |
                     (locTake & locParOk & ~locFound);
      addrParErr_reg <= (sysTake & ~sysParOk) | (locTake & ~locParOk);
      // local access aimed at a system bank starts nothing [R6]
      locIgnored_reg <= locTake & locParOk & locFound &
                        |(locPick & ~bankLocal); // [R13]
      locAccepted_reg <= locTake & locParOk & locFound &
                         |(locPick & bankLocal);
    end
  end

  // bridge: only system masters reach local banks; the router steers
  // control here while the data beats go straight between the buses
  always @(posedge clk_sys or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      bridgeActive_reg <= 1'b0;
      bridgeDone_reg <= 1'b0;
      bridgeCnt_reg <= {`CNT_W{1'b0}};
    end
    else
    begin
      bridgeDone_reg <= 1'b0;
      if (sysToLocal)
      begin
        bridgeActive_reg <= 1'b1; // [R5] [R16]
        bridgeCnt_reg <= 3'h1;
      end
      else if (bridgeActive_reg)
      begin
        if (bridgeCnt_reg == `BRIDGE_LAST)
        begin
          bridgeActive_reg <= 1'b0;
          bridgeDone_reg <= 1'b1; // [R14]
          bridgeCnt_reg <= {`CNT_W{1'b0}};
        end
        else
          bridgeCnt_reg <= bridgeCnt_reg + 3'h1;
      end
    end
  end

  // fixed priority, parked on the owner until it drops its request;
  // the grant is frozen while a crossing is in flight
  always @*
  begin
    grantNext = sysBusGrant_reg;
    if (!bridgeActive_reg && !(|(sysBusGrant_reg & sysBusReq)))
    begin
      grantNext = {`MASTERS{1'b0}};
      for (j = `MASTERS - 1; j >= 0; j = j - 1)
        if (sysBusReq[j])
        begin
          grantNext = {`MASTERS{1'b0}};
          grantNext[j] = 1'b1;
        end
    end
  end

  always @(posedge clk_sys or negedge rstnInt)
  begin
    if (!rstnInt)
      sysBusGrant_reg <= {`MASTERS{1'b0}};
    else
      sysBusGrant_reg <= grantNext; // [R21]
  end

  // falling edge capture buys half a clock of margin for slow buffers
  always @(negedge clk_sys or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      fallData_reg <= {`DATA_W{1'b0}};
      fallPar_reg <= {`DPAR_W{1'b0}};
    end
    else if (rdValid)
    begin
      fallData_reg <= rdData;
      fallPar_reg <= rdDataPar;
    end
  end

  always @*
  begin
    fallSel = fallingEdgeLatch & |(curUpm_reg & lineFourDisable); // [R22]
    capData = fallSel ? fallData_reg : rdData;
    capPar = fallSel ? fallPar_reg : rdDataPar;
    parBad = 1'b0;
    for (m = 0; m < `DPAR_W; m = m + 1)
      parBad = parBad | ~(capPar[m] ^ (^capData[m*8 +: 8])); // [R20]
  end

  always @(posedge clk_sys or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      readData_reg <= {`DATA_W{1'b0}};
      readValid_reg <= 1'b0;
      readParErr_reg <= 1'b0;
    end
    else
    begin
      readValid_reg <= rdValid;
      readParErr_reg <= rdValid & parBad;
      if (rdValid)
        readData_reg <= capData;
    end
  end
endmodule // memory_bank_decode_router

/* File: sim/memory_bank_decode_router_sva.sv */
`timescale 1ns/10ps
`include "bank_router_defines.vh"

module memory_bank_decode_router_sva (
  input wire clk_sys, // bus clock
  input wire rstn, // reset, low
  input wire sysReq, // system access
  input wire [`BANKS-1:0] sysBankSel_reg, // system bank
  input wire [`BANKS-1:0] locBankSel_reg, // local bank
  input wire dramStart_reg, // dram go
  input wire csStart_reg, // chip-select go
  input wire [`UPM_COUNT-1:0] upmStart_reg, // pattern go
  input wire noMatch_reg, // no hit
  input wire addrParErr_reg, // address parity
  input wire locIgnored_reg, // local dropped
  input wire bridgeActive_reg, // crossing
  input wire bridgeDone_reg // crossed
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire anyStart = dramStart_reg | csStart_reg | (|upmStart_reg);

  chk_sel_onehot: assert property (
    $onehot0(sysBankSel_reg) && $onehot0(locBankSel_reg))
    else $error("bank select not one-hot");
  chk_rsv_banks: assert property (
    sysBankSel_reg[9:8] == 2'h0 && locBankSel_reg[9:8] == 2'h0)
    else $error("reserved bank selected");
  chk_bridge_len: assert property (
    $rose(bridgeActive_reg) |->
      bridgeActive_reg [*4] ##1 (bridgeDone_reg && !bridgeActive_reg))
    else $error("bridge crossing length wrong");
  chk_sys_answer: assert property (
    sysReq && !bridgeActive_reg |=>
      (sysBankSel_reg != 12'h000) ^ noMatch_reg ^ addrParErr_reg)
    else $error("system access without single answer");
  chk_nomatch_idle: assert property (
    noMatch_reg |-> !anyStart && sysBankSel_reg == 12'h000
      && locBankSel_reg == 12'h000)
    else $error("machine started on unmatched address");
  chk_loc_drop: assert property (
    locIgnored_reg |-> !anyStart && !$rose(bridgeActive_reg))
    else $error("ignored local access started something");
  chk_bank_ram: assert property (
    locBankSel_reg[10] |-> upmStart_reg == 3'h4 && !csStart_reg)
    else $error("ram bank not on third pattern machine");
  chk_bank_periph: assert property (
    sysBankSel_reg[11] |-> csStart_reg && $rose(bridgeActive_reg))
    else $error("peripheral bank not crossed on chip select");
endmodule // memory_bank_decode_router_sva

bind memory_bank_decode_router memory_bank_decode_router_sva
  memory_bank_decode_router_sva_inst (.clk_sys, .rstn, .sysReq,
  .sysBankSel_reg, .locBankSel_reg, .dramStart_reg, .csStart_reg,
  .upmStart_reg, .noMatch_reg, .addrParErr_reg, .locIgnored_reg,
  .bridgeActive_reg, .bridgeDone_reg);

/* File: sim/ext_mem_model.sv */
`timescale 1ns/10ps

module ext_mem_model (
  input wire clk_sys, // bus clock
  input wire go, // send one read beat
  input wire [63:0] word, // beat data
  output reg rdValid, // beat valid
  output reg [63:0] rdData, // data pins
  output reg [7:0] rdDataPar // odd byte parity
);
  integer k;
  initial
  begin
    rdValid = 1'b0;
    rdData = 64'h0;
    rdDataPar = 8'h0;
  end
  always @(posedge clk_sys)
  begin
    rdValid <= go;
    if (go)
    begin
      rdData <= word;
      for (k = 0; k < 8; k = k + 1)
        rdDataPar[k] <= ~^word[k*8+:8];
    end
  end
  // data holds only to mid-beat, so a late sampler sees the inverse
  always @(negedge clk_sys)
    if (rdValid)
      rdData <= #2 ~rdData;
endmodule // ext_mem_model

/* File: sim/memory_bank_decode_router_test.sv */
`timescale 1ns/10ps
`include "bank_router_defines.vh"

module memory_bank_decode_router_test;
  reg clk_sys, rstn, fallingEdgeLatch, sysWide, sysReq, sysBurst;
  reg locReq, locBurst, go;
  reg [`BANKS*17-1:0] bankBase, compareMask;
  reg [`BANKS*12-1:0] dramCompareMask;
  reg [`BANKS*5-1:0] lowerDramMask;
  reg [`BANKS*3-1:0] machineChoice;
  reg [`BANKS*2-1:0] bankPortSize;
  reg [11:0] bankValid;
  reg [2:0] busChoiceBit, lineFourDisable;
  reg [3:0] sysBusReq, sysAddrPar, locAddrPar;
  reg [31:0] sysAddr, locAddr;
  reg [63:0] word;
  wire rdValid, dramStart_reg, csStart_reg, noMatch_reg, addrParErr_reg;
  wire locIgnored_reg, locAccepted_reg, bridgeActive_reg, bridgeDone_reg;
  wire readValid_reg, readParErr_reg;
  wire [63:0] rdData, readData_reg;
  wire [7:0] rdDataPar;
  wire [3:0] sysBusGrant_reg;
  wire [11:0] sysBankSel_reg, locBankSel_reg;
  wire [2:0] upmStart_reg, burstBeats_reg;
  wire [1:0] portSize_reg;
  integer fails, num_checks, i;
  localparam [14:0] CODES = {3'h6, 3'h5, 3'h4, 3'h1, 3'h0};
  localparam [24:0] STARTS = {5'h04, 5'h02, 5'h01, 5'h10, 5'h08};

  memory_bank_decode_router memory_bank_decode_router_inst (.clk_sys,
    .rstn, .bankBase, .compareMask, .dramCompareMask, .lowerDramMask,
    .machineChoice, .bankPortSize, .bankValid, .busChoiceBit,
    .lineFourDisable, .fallingEdgeLatch, .sysWide, .sysBusReq, .sysReq,
    .sysAddr, .sysAddrPar, .sysBurst, .locReq, .locAddr, .locAddrPar,
    .locBurst, .rdValid, .rdData, .rdDataPar, .sysBusGrant_reg,
    .sysBankSel_reg, .locBankSel_reg, .dramStart_reg, .csStart_reg,
    .upmStart_reg, .portSize_reg, .burstBeats_reg, .noMatch_reg,
    .addrParErr_reg, .locIgnored_reg, .locAccepted_reg, .bridgeActive_reg,
    .bridgeDone_reg, .readData_reg, .readValid_reg, .readParErr_reg);
  ext_mem_model ext_mem_model_inst (.clk_sys, .go, .word, .rdValid,
    .rdData, .rdDataPar);

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task chk(input [47:0] what, input [63:0] exp, input [63:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  function [3:0] apar(input [31:0] a);
    integer k;
  begin
    for (k = 0; k < 4; k = k + 1)
      apar[k] = ~^a[k*8+:8];
  end
  endfunction

  task cfg(input integer b, input [16:0] base, input [16:0] m,
    input [2:0] ms, input [1:0] ps);
  begin
    bankBase[b*17+:17] = base;
    compareMask[b*17+:17] = m;
    machineChoice[b*3+:3] = ms;
    bankPortSize[b*2+:2] = ps;
    bankValid[b] = 1'b1;
  end
  endtask

  // flags are {noMatch, parity, ignored, bridge, accepted}
  task access(input l, input [31:0] a, input b, input bad,
    input [11:0] eSel, input [4:0] eSt, input [4:0] eFl);
  begin
    {sysReq, locReq} = {~l, l};
    {sysAddr, locAddr} = {a, a};
    {sysBurst, locBurst} = {b, b};
    {sysAddrPar, locAddrPar} = {2{apar(a) ^ {3'h0, bad}}};
    @(negedge clk_sys);
    {sysReq, locReq} = 2'b00;
    chk("sel", eSel, l ? locBankSel_reg : sysBankSel_reg);
    chk("start", eSt, {dramStart_reg, csStart_reg, upmStart_reg});
    chk("flags", eFl, {noMatch_reg, addrParErr_reg, locIgnored_reg,
      bridgeActive_reg, locAccepted_reg});
    @(negedge clk_sys);
  end
  endtask

  task waitB(input integer n, input [1:0] exp);
  begin
    repeat (n) @(negedge clk_sys);
    chk("bridge", exp, {bridgeActive_reg, bridgeDone_reg});
  end
  endtask

  task readBeat(input [63:0] a, input [63:0] exp);
  begin
    go = 1'b1;
    word = a;
    @(negedge clk_sys);
    go = 1'b0;
    @(negedge clk_sys);
    chk("rdata", exp, readData_reg);
    chk("rflags", 2'b10, {readValid_reg, readParErr_reg});
  end
  endtask

  task grantStep(input [3:0] req, input [3:0] exp);
  begin
    sysBusReq = req;
    @(negedge clk_sys);
    chk("grant", exp, sysBusGrant_reg);
  end
  endtask

  task end_sim;
  begin
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  initial
  begin
    repeat (600) @(posedge clk_sys);
    fails = fails + 1;
    end_sim;
  end

  initial
  begin
    fails = 0;
    num_checks = 0;
    {rstn, fallingEdgeLatch, sysReq, sysBurst, locReq, locBurst} = 6'h0;
    {go, sysBusReq, busChoiceBit, lineFourDisable} = 11'h0;
    {sysAddr, locAddr, sysAddrPar, locAddrPar, word} = 136'h0;
    sysWide = 1'b1;
    {bankBase, compareMask, machineChoice, bankPortSize} = 468'h0;
    {dramCompareMask, lowerDramMask} = '1;
    bankValid = 12'h000;
    cfg(0, 17'h00010, 17'h1fff0, 3'h0, 2'h0);
    cfg(1, 17'h00010, 17'h1ffff, 3'h4, 2'h0);
    cfg(2, 17'h00100, 17'h00000, 3'h1, 2'h2);
    cfg(3, 17'h00180, 17'h1ffff, 3'h5, 2'h1);
    cfg(8, 17'h00400, 17'h1ffff, 3'h0, 2'h0);
    cfg(9, 17'h00400, 17'h1ffff, 3'h0, 2'h0);
    cfg(10, 17'h00200, 17'h1ffff, 3'h0, 2'h3);
    cfg(11, 17'h00300, 17'h1ffff, 3'h0, 2'h0);
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (i = 0; i < 5; i = i + 1)
    begin
      machineChoice[2:0] = CODES[i*3+:3];
      access(0, 32'h0008_0000, 0, 0, 12'h001, STARTS[i*5+:5], 5'h0);
    end
    machineChoice[2:0] = 3'h0;
    access(0, 32'h0008_0000, 1, 0, 12'h001, 5'h08, 5'h0);
    chk("size", {2'h0, 3'h4}, {portSize_reg, burstBeats_reg});
    sysWide = 1'b0;
    access(0, 32'h0008_0000, 0, 0, 12'h001, 5'h08, 5'h0);
    chk("size", {2'h1, 3'h1}, {portSize_reg, burstBeats_reg});
    $display("test machines and widths done");
    access(0, 32'h000f_8000, 0, 0, 12'h001, 5'h08, 5'h00);
    access(0, 32'h0088_0000, 0, 0, 12'h000, 5'h00, 5'h10);
    access(0, 32'h0080_0000, 0, 0, 12'h004, 5'h10, 5'h00);
    chk("size", {2'h2, 3'h1}, {portSize_reg, burstBeats_reg});
    access(0, 32'h0200_0000, 0, 0, 12'h000, 5'h00, 5'h10);
    access(0, 32'h0008_0000, 0, 1, 12'h000, 5'h00, 5'h08);
    $display("test decode done");
    access(1, 32'h0100_0000, 1, 0, 12'h400, 5'h04, 5'h01);
    chk("size", {2'h3, 3'h4}, {portSize_reg, burstBeats_reg});
    fallingEdgeLatch = 1'b1;
    lineFourDisable = 3'h4;
    readBeat(64'h0123_4567_89ab_cdef, 64'h0123_4567_89ab_cdef);
    fallingEdgeLatch = 1'b0;
    readBeat(64'h0123_4567_89ab_cdef, 64'hfedc_ba98_7654_3210);
    access(1, 32'h0008_0000, 0, 0, 12'h000, 5'h00, 5'h04);
    access(1, 32'h0180_0000, 0, 0, 12'h800, 5'h08, 5'h01);
    $display("test local bus and reads done");
    access(0, 32'h0180_0000, 0, 0, 12'h800, 5'h08, 5'h02);
    access(0, 32'h0008_0000, 0, 0, 12'h000, 5'h00, 5'h02);
    waitB(1, 2'b01);
    busChoiceBit = 3'h2;
    access(0, 32'h00c0_0000, 0, 0, 12'h008, 5'h02, 5'h02);
    waitB(2, 2'b10);
    waitB(1, 2'b01);
    access(1, 32'h00c0_0000, 0, 0, 12'h008, 5'h02, 5'h01);
    $display("test bridge done");
    grantStep(4'hc, 4'h4);
    grantStep(4'he, 4'h4);
    grantStep(4'ha, 4'h2);
    $display("test arbitration done");
    end_sim;
  end
endmodule // memory_bank_decode_router_test
